// ===== pkg/front_panel_pkg.sv
// Constants, field layouts, defaults and timing for the front-panel menu controller.
// Assumes a 10 MHz aclk and 32-bit AXI4-Lite register access.
package front_panel_pkg;

  typedef logic [31:0] word_t;

  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int TEST_MS = 2000;
  localparam int TEST_CYC = TEST_MS * CYC_PER_MS;
  localparam int INIT_MS = 3000;
  localparam int INIT_CYC = INIT_MS * CYC_PER_MS;
  localparam int ACK_MS = 1000;
  localparam int ACK_CYC = ACK_MS * CYC_PER_MS;
  localparam int DEBOUNCE_MS = 20;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;

  // Menu and service code
  localparam logic [3:0] PRO_TOP = 4'h0;
  localparam logic [3:0] PRO_SERVICE = 4'h9;
  localparam logic [6:0] RESTORE_CODE = 7'h42;
  localparam logic [6:0] CODE_MAX = 7'h63;

  // Parameter store, word index = byte address / 4 - 1
  localparam int NPARAM = 9;
  localparam int VALUE_W = 20;
  localparam logic [3:0] P_PERMS = 4'h0;
  localparam logic [3:0] P_AL1 = 4'h1;
  localparam logic [3:0] P_AL2 = 4'h2;
  localparam logic [3:0] P_HYS1 = 4'h3;
  localparam logic [3:0] P_HYS2 = 4'h4;
  localparam logic [3:0] P_SERIAL = 4'h5;
  localparam logic [3:0] P_TOTSCALE = 4'h6;
  localparam logic [3:0] P_ANHIGH = 4'h7;
  localparam logic [3:0] P_DECPT = 4'h8;

  // Byte addresses
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_PERMS = 8'h04;
  localparam logic [7:0] ADDR_DECPT = 8'h24;

  // Access permission bits
  localparam int PERM_W = 9;
  localparam int PERM_DSP_AL = 0;
  localparam int PERM_ENT_AL = 1;
  localparam int PERM_DSP_HYS = 2;
  localparam int PERM_RST_AL = 3;
  localparam int PERM_DSP_BUF = 4;
  localparam int PERM_RST_BUF = 5;
  localparam int PERM_SEL_DSP = 6;
  localparam int PERM_RST_TOT = 7;
  localparam int PERM_TARE = 8;

  // Serial word: baud [1:0] (0=300,1=600,2=1200,3=2400), address [8:2],
  // print selection [12:9], full transmission [13]
  localparam int SER_BAUD_LSB = 0;
  localparam int SER_ADDR_LSB = 2;
  localparam int SER_PRINT_LSB = 9;
  localparam int SER_FULL_BIT = 13;

  localparam word_t PARAM_DEFAULT [0:NPARAM-1] = '{
    32'h0000_01FF, 32'h0000_0000, 32'h0000_0000, 32'h0000_0001, 32'h0000_0001,
    32'h0000_2002, 32'h0000_03E8, 32'h0000_2710, 32'h0000_0002};
  localparam word_t PARAM_MASK [0:NPARAM-1] = '{
    32'h0000_01FF, 32'h000F_FFFF, 32'h000F_FFFF, 32'h000F_FFFF, 32'h000F_FFFF,
    32'h0000_3FFF, 32'h000F_FFFF, 32'h000F_FFFF, 32'h0000_0007};

  // Messages on the display
  localparam logic [2:0] MSG_NONE = 3'h0;
  localparam logic [2:0] MSG_INIT = 3'h1;
  localparam logic [2:0] MSG_LOCK = 3'h2;
  localparam logic [2:0] MSG_TARE = 3'h3;
  localparam logic [2:0] MSG_TOTAL = 3'h4;

  // Quick programming steps in scroll order
  localparam logic [2:0] Q_AL1 = 3'h0;
  localparam logic [2:0] Q_HYS1 = 3'h1;
  localparam logic [2:0] Q_AL2 = 3'h2;
  localparam logic [2:0] Q_HYS2 = 3'h3;
  localparam logic [2:0] Q_ALARM1_LATCHED_STEP = 3'h4;
  localparam logic [2:0] Q_ALARM2_LATCHED_STEP = 3'h5;
  localparam logic [2:0] Q_PEAK_STEP = 3'h6;
  localparam logic [2:0] Q_VALLEY_STEP = 3'h7;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_TEST, ST_METER, ST_ACK, ST_MENU, ST_CODE, ST_INIT, ST_QUICK
  } state_t;

endpackage

// ===== core/key_debounce.sv
// Synchroniser and debounce filter for one front-panel pin.
// Assumes raw is asynchronous; level_q follows it after CYC stable cycles.
`timescale 1ns/1ps
module key_debounce #(
  parameter int CYC = front_panel_pkg::DEBOUNCE_CYC,
  parameter logic IDLE = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic raw,
  output logic level_q
);
  logic sync1_q;
  logic sync2_q;
  logic [31:0] cnt_q;
  wire differs = sync2_q != level_q;
  wire settled = cnt_q == 32'(CYC - 1);

  // Two flops, then a stability count (see RULE19)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= IDLE;
      sync2_q <= IDLE;
      cnt_q <= 32'h0000_0000;
      level_q <= IDLE;
    end else if (ce) begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
      cnt_q <= (differs && !settled) ? cnt_q + 32'h0000_0001 : 32'h0000_0000;
      if (differs && settled) begin
        level_q <= sync2_q;
      end
    end
  end
endmodule

// ===== core/front_panel_menu_control.sv
// Front-panel key and menu controller with an AXI4-Lite parameter store.
// Assumes debounced-by-this-block key pins, same-clock meter status inputs.
//
// Notes on behaviour
// (RULE1) Service code 66 plus program restores defaults
// (RULE2) Restore shows init message, then top menu
// (RULE3) All segments lit two seconds after power-up
// (RULE4) Power-up restores last input or total view
// (RULE5) Down shows input, up shows total
// (RULE6) Minus sign and leading zero flags
// (RULE7) Lockout limits access to permitted steps
// (RULE8) Lockout with nothing permitted shows lock message
// (RULE9) Quick edits apply only on program press
// (RULE10) Latched-alarm steps only when latched; down+program clears
// (RULE11) Down+program clears peak or valley
// (RULE12) Meter keys need permission; down+program zeroes input
// (RULE13) Up+program clears totalizer when permitted
// (RULE14) Program enters full or quick programming
// (RULE15) Chord operations show a brief acknowledgment; only the meter tare and total chords do, the quick-mode clear chords show none
// (RULE16) Factory defaults for serial, scale, analog, permissions
// (RULE17) Unknown service code returns to top menu
// (RULE18) Program edge with key held is chord only; in quick mode it also commits on an editable value step and moves to the next step
// (RULE19) Keys debounced before edge detection
`timescale 1ns/1ps
module front_panel_menu_control #(
  parameter int TEST_CYC = front_panel_pkg::TEST_CYC,
  parameter int INIT_CYC = front_panel_pkg::INIT_CYC,
  parameter int ACK_CYC = front_panel_pkg::ACK_CYC,
  parameter int DEBOUNCE_CYC = front_panel_pkg::DEBOUNCE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic key_up,
  input wire logic key_down,
  input wire logic key_prog,
  input wire logic program_lockout_input_n,
  input wire logic saved_total_mode,
  input wire logic reading_negative,
  input wire logic alarm1_latched,
  input wire logic alarm2_latched,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic all_segments_on_q,
  output logic show_total_q,
  output logic [2:0] message_q,
  output logic minus_sign_q,
  output logic lead_zero_q,
  output logic tare_pulse_q,
  output logic total_clear_q,
  output logic alarm1_clear_q,
  output logic alarm2_clear_q,
  output logic peak_clear_q,
  output logic valley_clear_q,
  output logic alarm_apply_q
);
  typedef front_panel_pkg::word_t word_t;

  front_panel_pkg::state_t state_q;
  word_t params_q [0:front_panel_pkg::NPARAM-1];
  logic [31:0] timer_q;
  logic [3:0] menu_q;
  logic [6:0] code_q;
  logic [2:0] quick_step_q;
  logic [19:0] edit_q;
  logic up_lv, dn_lv, pg_lv, lock_n_lv;
  logic up_prev_q, dn_prev_q, pg_prev_q, up_chorded_q, dn_chorded_q;
  logic nv_s1_q, nv_s2_q;

  key_debounce #(.CYC(DEBOUNCE_CYC), .IDLE(1'b0)) u_up (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .raw(key_up), .level_q(up_lv));
  key_debounce #(.CYC(DEBOUNCE_CYC), .IDLE(1'b0)) u_dn (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .raw(key_down), .level_q(dn_lv));
  key_debounce #(.CYC(DEBOUNCE_CYC), .IDLE(1'b0)) u_pg (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .raw(key_prog), .level_q(pg_lv));
  key_debounce #(.CYC(DEBOUNCE_CYC), .IDLE(1'b1)) u_lock (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .raw(program_lockout_input_n), .level_q(lock_n_lv));

  // Key events; a chord suppresses the held key's own release action (see RULE18)
  wire lock_lv = ~lock_n_lv;
  wire pg_rise = pg_lv & ~pg_prev_q;
  wire chord_up = pg_rise & up_lv;
  wire chord_dn = pg_rise & dn_lv & ~up_lv;
  wire prog_single = pg_rise & ~up_lv & ~dn_lv;
  wire up_evt = ~up_lv & up_prev_q & ~up_chorded_q;
  wire dn_evt = ~dn_lv & dn_prev_q & ~dn_chorded_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      up_prev_q <= 1'b0;
      dn_prev_q <= 1'b0;
      pg_prev_q <= 1'b0;
      up_chorded_q <= 1'b0;
      dn_chorded_q <= 1'b0;
      nv_s1_q <= 1'b0;
      nv_s2_q <= 1'b0;
    end else if (ce) begin
      up_prev_q <= up_lv;
      dn_prev_q <= dn_lv;
      pg_prev_q <= pg_lv;
      up_chorded_q <= (pg_rise & up_lv) | (up_chorded_q & ~(up_lv & ~up_prev_q));
      dn_chorded_q <= (pg_rise & dn_lv) | (dn_chorded_q & ~(dn_lv & ~dn_prev_q));
      nv_s1_q <= saved_total_mode;
      nv_s2_q <= nv_s1_q;
    end
  end

  // Quick step selection from permissions and latch state (see RULE7, RULE10)
  wire [8:0] perm = params_q[front_panel_pkg::P_PERMS][front_panel_pkg::PERM_W-1:0];
  wire [7:0] q_en = {perm[front_panel_pkg::PERM_DSP_BUF], perm[front_panel_pkg::PERM_DSP_BUF],
    perm[front_panel_pkg::PERM_RST_AL] & alarm2_latched,
    perm[front_panel_pkg::PERM_RST_AL] & alarm1_latched,
    perm[front_panel_pkg::PERM_DSP_HYS], perm[front_panel_pkg::PERM_DSP_AL],
    perm[front_panel_pkg::PERM_DSP_HYS], perm[front_panel_pkg::PERM_DSP_AL]};

  function automatic logic [3:0] seek(input logic [7:0] en, input logic [3:0] from);
    logic [3:0] r;
    r = 4'h8;
    for (int i = 7; i >= 0; i--) begin
      if (i >= int'(from) && en[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [3:0] step_param(input logic [2:0] s);
    case (s)
      front_panel_pkg::Q_HYS1: return front_panel_pkg::P_HYS1;
      front_panel_pkg::Q_AL2: return front_panel_pkg::P_AL2;
      front_panel_pkg::Q_HYS2: return front_panel_pkg::P_HYS2;
      default: return front_panel_pkg::P_AL1;
    endcase
  endfunction

  wire [3:0] q_first = seek(q_en, 4'h0);
  wire [3:0] q_next = seek(q_en, {1'b0, quick_step_q} + 4'h1);
  wire [19:0] first_val = params_q[step_param(q_first[2:0])][19:0];
  wire [19:0] next_val = params_q[step_param(q_next[2:0])][19:0];
  wire value_step = quick_step_q <= front_panel_pkg::Q_HYS2;
  wire can_edit = value_step & perm[front_panel_pkg::PERM_ENT_AL];
  wire in_quick = state_q == front_panel_pkg::ST_QUICK;
  wire in_meter = state_q == front_panel_pkg::ST_METER;
  wire quick_commit = in_quick & pg_rise & can_edit;
  wire do_restore = (state_q == front_panel_pkg::ST_CODE) & prog_single &
    (code_q == front_panel_pkg::RESTORE_CODE);
  wire timer_zero = timer_q == 32'h0000_0000;
  wire [3:0] commit_idx = step_param(quick_step_q);

  // Menu and key state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= front_panel_pkg::ST_TEST;
      timer_q <= 32'(TEST_CYC - 1);
      all_segments_on_q <= 1'b1;
      show_total_q <= 1'b0;
      message_q <= front_panel_pkg::MSG_NONE;
      menu_q <= front_panel_pkg::PRO_TOP;
      code_q <= 7'h00;
      quick_step_q <= 3'h0;
      edit_q <= 20'h00000;
      {tare_pulse_q, total_clear_q, alarm1_clear_q, alarm2_clear_q} <= 4'h0;
      {peak_clear_q, valley_clear_q, alarm_apply_q} <= 3'h0;
      minus_sign_q <= 1'b0;
      lead_zero_q <= 1'b0;
    end else if (ce) begin
      {tare_pulse_q, total_clear_q, alarm1_clear_q, alarm2_clear_q} <= 4'h0;
      {peak_clear_q, valley_clear_q, alarm_apply_q} <= 3'h0;
      if (!timer_zero) begin
        timer_q <= timer_q - 32'h0000_0001;
      end
      // Sign and decimal-point zero flags for the shown value (see RULE6)
      minus_sign_q <= reading_negative & in_meter;
      lead_zero_q <= (params_q[front_panel_pkg::P_DECPT] != 32'h0000_0000) & in_meter;
      case (state_q)
        front_panel_pkg::ST_TEST: begin
          if (timer_zero) begin // see RULE3
            state_q <= front_panel_pkg::ST_METER;
            all_segments_on_q <= 1'b0;
            show_total_q <= nv_s2_q; // see RULE4
          end
        end
        front_panel_pkg::ST_METER: begin
          if (chord_dn) begin
            if (perm[front_panel_pkg::PERM_TARE]) begin // see RULE12
              tare_pulse_q <= 1'b1;
              message_q <= front_panel_pkg::MSG_TARE; // see RULE15
              state_q <= front_panel_pkg::ST_ACK;
              timer_q <= 32'(ACK_CYC - 1);
            end
          end else if (chord_up) begin
            if (perm[front_panel_pkg::PERM_RST_TOT]) begin // see RULE13
              total_clear_q <= 1'b1;
              message_q <= front_panel_pkg::MSG_TOTAL; // see RULE15
              state_q <= front_panel_pkg::ST_ACK;
              timer_q <= 32'(ACK_CYC - 1);
            end
          end else if (prog_single) begin
            if (!lock_lv) begin // see RULE14
              state_q <= front_panel_pkg::ST_MENU;
              menu_q <= front_panel_pkg::PRO_TOP;
            end else if (q_first[3]) begin // see RULE8
              message_q <= front_panel_pkg::MSG_LOCK;
              state_q <= front_panel_pkg::ST_ACK;
              timer_q <= 32'(ACK_CYC - 1);
            end else begin // see RULE7
              state_q <= front_panel_pkg::ST_QUICK;
              quick_step_q <= q_first[2:0];
              edit_q <= first_val;
            end
          end else if (dn_evt & perm[front_panel_pkg::PERM_SEL_DSP]) begin
            show_total_q <= 1'b0; // see RULE5
          end else if (up_evt & perm[front_panel_pkg::PERM_SEL_DSP]) begin
            show_total_q <= 1'b1; // see RULE5
          end
        end
        front_panel_pkg::ST_ACK: begin
          if (timer_zero) begin
            state_q <= front_panel_pkg::ST_METER;
            message_q <= front_panel_pkg::MSG_NONE;
          end
        end
        front_panel_pkg::ST_MENU: begin
          if (prog_single) begin
            if (menu_q == front_panel_pkg::PRO_SERVICE) begin
              state_q <= front_panel_pkg::ST_CODE;
              code_q <= 7'h00;
            end else if (menu_q == front_panel_pkg::PRO_TOP) begin
              state_q <= front_panel_pkg::ST_METER;
            end else begin
              menu_q <= front_panel_pkg::PRO_TOP;
            end
          end else if (up_evt) begin
            menu_q <= (menu_q == front_panel_pkg::PRO_SERVICE) ? front_panel_pkg::PRO_TOP :
              menu_q + 4'h1;
          end else if (dn_evt) begin
            menu_q <= (menu_q == front_panel_pkg::PRO_TOP) ? front_panel_pkg::PRO_SERVICE :
              menu_q - 4'h1;
          end
        end
        front_panel_pkg::ST_CODE: begin
          if (do_restore) begin // see RULE1
            state_q <= front_panel_pkg::ST_INIT;
            message_q <= front_panel_pkg::MSG_INIT;
            timer_q <= 32'(INIT_CYC - 1);
          end else if (prog_single) begin // see RULE17
            state_q <= front_panel_pkg::ST_MENU;
            menu_q <= front_panel_pkg::PRO_TOP;
          end else if (up_evt) begin
            code_q <= (code_q == front_panel_pkg::CODE_MAX) ? 7'h00 : code_q + 7'h01;
          end else if (dn_evt) begin
            code_q <= (code_q == 7'h00) ? front_panel_pkg::CODE_MAX : code_q - 7'h01;
          end
        end
        front_panel_pkg::ST_INIT: begin
          if (timer_zero) begin // see RULE2
            state_q <= front_panel_pkg::ST_MENU;
            menu_q <= front_panel_pkg::PRO_TOP;
            message_q <= front_panel_pkg::MSG_NONE;
          end
        end
        front_panel_pkg::ST_QUICK: begin
          if (pg_rise) begin
            alarm_apply_q <= can_edit; // see RULE9
            if (chord_dn & perm[front_panel_pkg::PERM_RST_AL]) begin // see RULE10
              alarm1_clear_q <= quick_step_q == front_panel_pkg::Q_ALARM1_LATCHED_STEP;
              alarm2_clear_q <= quick_step_q == front_panel_pkg::Q_ALARM2_LATCHED_STEP;
            end
            if (chord_dn & perm[front_panel_pkg::PERM_RST_BUF]) begin // see RULE11
              peak_clear_q <= quick_step_q == front_panel_pkg::Q_PEAK_STEP;
              valley_clear_q <= quick_step_q == front_panel_pkg::Q_VALLEY_STEP;
            end
            if (q_next[3]) begin
              state_q <= front_panel_pkg::ST_METER;
            end else begin
              quick_step_q <= q_next[2:0];
              edit_q <= next_val;
            end
          end else if (up_evt & can_edit) begin
            edit_q <= edit_q + 20'h00001;
          end else if (dn_evt & can_edit) begin
            edit_q <= edit_q - 20'h00001;
          end
        end
        default: begin
          state_q <= front_panel_pkg::ST_METER;
        end
      endcase
    end
  end

  // AXI4-Lite slave
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_have_q, w_have_q;
  wire [5:0] wr_word = awaddr_q[7:2];
  wire [5:0] rd_word = araddr[7:2];
  wire wr_hit = (wr_word != 6'h00) && (wr_word <= 6'(front_panel_pkg::NPARAM));
  wire rd_hit = rd_word <= 6'(front_panel_pkg::NPARAM);
  wire [3:0] wr_pidx = 4'(wr_word - 6'h01);
  wire [3:0] rd_pidx = 4'(rd_word - 6'h01);
  wire wr_go = aw_have_q & w_have_q & ~bvalid;
  wire [31:0] wr_bits = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [31:0] wr_merged = (params_q[wr_pidx] & ~wr_bits) | (wdata_q & wr_bits);
  wire [31:0] status_w = {9'h000, code_q, menu_q, quick_step_q, message_q, lock_lv,
    show_total_q, 4'(state_q)};
  wire [31:0] rd_value = (rd_word == 6'h00) ? status_w :
    rd_hit ? params_q[rd_pidx] : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {awready, wready, arready} <= 3'h7;
      {bvalid, rvalid, aw_have_q, w_have_q} <= 4'h0;
      bresp <= front_panel_pkg::RESP_OKAY;
      rresp <= front_panel_pkg::RESP_OKAY;
      rdata <= 32'h0000_0000;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        awaddr_q <= awaddr;
        aw_have_q <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        wdata_q <= wdata;
        wstrb_q <= wstrb;
        w_have_q <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? front_panel_pkg::RESP_OKAY : front_panel_pkg::RESP_SLVERR;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_value;
        rresp <= rd_hit ? front_panel_pkg::RESP_OKAY : front_panel_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // Parameter store: restore, then quick commit, then bus write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < front_panel_pkg::NPARAM; i++) begin
        params_q[i] <= front_panel_pkg::PARAM_DEFAULT[i];
      end
    end else if (ce && do_restore) begin
      for (int i = 0; i < front_panel_pkg::NPARAM; i++) begin
        params_q[i] <= front_panel_pkg::PARAM_DEFAULT[i]; // see RULE1, RULE16
      end
    end else if (ce && quick_commit) begin
      params_q[commit_idx] <= {12'h000, edit_q} & front_panel_pkg::PARAM_MASK[commit_idx];
    end else if (wr_go && wr_hit) begin
      params_q[wr_pidx] <= wr_merged & front_panel_pkg::PARAM_MASK[wr_pidx];
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  restore_defaults_a: assert property (ce && do_restore |=> // see RULE1 see RULE16
    params_q[front_panel_pkg::P_SERIAL] == 32'h0000_2002 &&
    params_q[front_panel_pkg::P_PERMS] == 32'h0000_01FF &&
    state_q == front_panel_pkg::ST_INIT) else $error("restore did not load defaults");
  init_return_a: assert property (ce && state_q == front_panel_pkg::ST_INIT && timer_zero |=>
    state_q == front_panel_pkg::ST_MENU && menu_q == 4'h0) else $error("no return after init"); // see RULE2
  test_lamps_a: assert property (all_segments_on_q |-> // see RULE3
    state_q == front_panel_pkg::ST_TEST && timer_q < 32'(TEST_CYC)) else $error("lamp test leak");
  mode_restore_a: assert property (ce && state_q == front_panel_pkg::ST_TEST && timer_zero |=> // see RULE4
    show_total_q == $past(nv_s2_q)) else $error("display mode not restored");
  down_select_a: assert property (ce && in_meter && !pg_rise && dn_evt && // see RULE5
    perm[front_panel_pkg::PERM_SEL_DSP] |=> !show_total_q) else $error("down did not select input");
  lock_message_a: assert property (ce && in_meter && prog_single && lock_lv && perm == 9'h000 // see RULE8
    |=> state_q == front_panel_pkg::ST_ACK && message_q == front_panel_pkg::MSG_LOCK)
    else $error("lock message missing");
  quick_apply_a: assert property (ce && quick_commit |=> alarm_apply_q && // see RULE9
    params_q[$past(commit_idx)][19:0] == $past(edit_q)) else $error("quick value not applied");
  latch_clear_a: assert property (alarm1_clear_q |-> $past(chord_dn)) // see RULE10
    else $error("latch cleared without chord");
  tare_chord_a: assert property (ce && in_meter && chord_dn && perm[front_panel_pkg::PERM_TARE] // see RULE12
    |=> tare_pulse_q && message_q == front_panel_pkg::MSG_TARE) else $error("tare missing");
  code_reject_a: assert property (ce && state_q == front_panel_pkg::ST_CODE && prog_single && // see RULE17
    code_q != 7'h42 |=> state_q == front_panel_pkg::ST_MENU && menu_q == 4'h0)
    else $error("bad code not rejected");
  chord_only_a: assert property (ce && in_meter && up_chorded_q && !up_lv && // see RULE18
    up_prev_q && !dn_evt |=> show_total_q == $past(show_total_q))
    else $error("chord fired single");
endmodule

// ===== tb/key_operator.sv
// Operator model: presses and releases the front-panel keys and the lockout pin.
// Assumes the bench calls hit right after a rising aclk edge.
`timescale 1ns/1ps
module key_operator (
  input wire logic aclk,
  output logic key_up,
  output logic key_down,
  output logic key_prog,
  output logic lockout_n
);
  initial begin
    key_up = 1'b0;
    key_down = 1'b0;
    key_prog = 1'b0;
    lockout_n = 1'b1;
  end
  // Change one pin, then hold it well past the debounce time
  task automatic hit(input int k, input logic v);
    case (k)
      0: key_up <= v;
      1: key_down <= v;
      2: key_prog <= v;
      default: lockout_n <= v;
    endcase
    repeat (12) @(posedge aclk);
  endtask
endmodule

// ===== tb/front_panel_menu_control_bench.sv
// Self-checking bench for the front-panel menu controller.
// Assumes shortened timers: test 50, init 40, ack 20, debounce 4 cycles.
`timescale 1ns/1ps
module front_panel_menu_control_bench;
  logic aclk, aresetn, ce, saved_total_mode, reading_negative, alarm1_latched, alarm2_latched;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [2:0] message_q;
  logic all_segments_on_q, show_total_q, minus_sign_q, lead_zero_q, tare_pulse_q;
  logic total_clear_q, alarm1_clear_q, alarm2_clear_q, peak_clear_q, valley_clear_q;
  logic alarm_apply_q;
  wire logic key_up, key_down, key_prog, program_lockout_input_n;
  int n_errors = 0, n_checks = 0, n_tare = 0, n_tot = 0, n_ap = 0, n_al = 0, n_buf = 0;
  front_panel_menu_control #(.TEST_CYC(50), .INIT_CYC(40), .ACK_CYC(20), .DEBOUNCE_CYC(4))
    dut (.*);
  key_operator op (.aclk, .key_up, .key_down, .key_prog, .lockout_n(program_lockout_input_n));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    n_tare <= n_tare + int'(tare_pulse_q);
    n_tot <= n_tot + int'(total_clear_q);
    n_ap <= n_ap + int'(alarm_apply_q);
    n_al <= n_al + int'(alarm1_clear_q) + int'(alarm2_clear_q);
    n_buf <= n_buf + int'(peak_clear_q) + int'(valley_clear_q);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic t;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin @(negedge aclk); t = arready; @(posedge aclk); end while (!t);
    arvalid <= 1'b0;
    do begin @(negedge aclk); t = rvalid; d = rdata; r = rresp; @(posedge aclk); end while (!t);
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    ta = 1'b0; tw = 1'b0;
    awaddr <= a; wdata <= v; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(negedge aclk); ta |= awready; tw |= wready; @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (!(ta && tw));
    do begin @(negedge aclk); tb = bvalid; r = bresp; @(posedge aclk); end while (!tb);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, reading_negative} = '0;
    {alarm1_latched, alarm2_latched, awaddr, araddr, wdata, wstrb} = '0;
    ce = 1'b1; saved_total_mode = 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(all_segments_on_q, 1'b1);
    repeat (52) @(posedge aclk);
    chk(all_segments_on_q, 1'b0);
    chk(show_total_q, 1'b1);
    op.hit(1, 1'b1); op.hit(1, 1'b0);
    chk(show_total_q, 1'b0);
    op.hit(0, 1'b1); op.hit(0, 1'b0);
    chk(show_total_q, 1'b1);
    reading_negative <= 1'b1;
    repeat (2) @(posedge aclk);
    chk(minus_sign_q, 1'b1);
    chk(lead_zero_q, 1'b1);
    reading_negative <= 1'b0;
    op.hit(1, 1'b1); op.hit(2, 1'b1);
    chk(message_q, 3'h3);
    op.hit(2, 1'b0); op.hit(1, 1'b0);
    chk(n_tare, 1);
    chk(show_total_q, 1'b1);
    repeat (30) @(posedge aclk);
    op.hit(0, 1'b1); op.hit(2, 1'b1);
    chk(message_q, 3'h4);
    op.hit(2, 1'b0); op.hit(0, 1'b0);
    chk(n_tot, 1);
    repeat (30) @(posedge aclk);
    rd(8'h04);
    chk(d, 32'h0000_01FF);
    rd(8'h18);
    chk(d, 32'h0000_2002);
    rd(8'hFC);
    chk(r, 2'h2);
    wr(8'h04, 32'h0000_0000);
    chk(r, 2'h0);
    op.hit(3, 1'b0); op.hit(2, 1'b1);
    chk(message_q, 3'h2);
    // Quick mode: alarm edit, latch clear, peak alone, valley chord
    wr(8'h04, 32'h0000_003B);
    alarm1_latched <= 1'b1;
    op.hit(2, 1'b0);
    op.hit(2, 1'b1);
    op.hit(2, 1'b0);
    op.hit(0, 1'b1);
    op.hit(0, 1'b0);
    rd(8'h08);
    chk(d, 32'h0000_0000);
    op.hit(2, 1'b1);
    rd(8'h08);
    chk(d, 32'h0000_0001);
    op.hit(2, 1'b0);
    op.hit(2, 1'b1);
    op.hit(2, 1'b0);
    op.hit(1, 1'b1);
    op.hit(2, 1'b1);
    op.hit(2, 1'b0);
    op.hit(1, 1'b0);
    op.hit(2, 1'b1);
    op.hit(2, 1'b0);
    op.hit(1, 1'b1);
    op.hit(2, 1'b1);
    op.hit(2, 1'b0);
    op.hit(1, 1'b0);
    chk(n_ap, 2);
    chk(n_al, 1);
    chk(n_buf, 1);
    // Service menu: wrong code, then the restore code
    op.hit(3, 1'b1);
    op.hit(2, 1'b1);
    op.hit(2, 1'b0);
    op.hit(1, 1'b1);
    op.hit(1, 1'b0);
    op.hit(2, 1'b1);
    op.hit(2, 1'b0);
    op.hit(2, 1'b1);
    rd(8'h00);
    chk(d & 32'h0000_F00F, 32'h0000_0003);
    op.hit(2, 1'b0);
    op.hit(1, 1'b1);
    op.hit(1, 1'b0);
    op.hit(2, 1'b1);
    op.hit(2, 1'b0);
    repeat (34) begin
      op.hit(1, 1'b1);
      op.hit(1, 1'b0);
    end
    op.hit(2, 1'b1);
    chk(message_q, 3'h1);
    op.hit(2, 1'b0);
    repeat (30) @(posedge aclk);
    rd(8'h00);
    chk(d & 32'h0000_F1CF, 32'h0000_0003);
    rd(8'h04);
    chk(d, 32'h0000_01FF);
    rd(8'h08);
    chk(d, 32'h0000_0000);
    tally_and_finish();
  end
  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    tally_and_finish();
  end
endmodule
